// ==== verilog/spsw_pkg.sv ====
// spsw_pkg: constants and types of the serial switch command port.
// assumes one 8-bit frame per device per chip select window.
package spsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int unsigned SPSW_FRAME_BITS  = 8;
  localparam int unsigned SPSW_CHANNELS    = 6;
  localparam int unsigned SPSW_CNT_W       = 3;
  localparam int unsigned SPSW_WRITE_BIT   = 7;
  localparam int unsigned SPSW_BANK_BIT    = 6;
  localparam int unsigned SPSW_PTR_HI      = 5;
  localparam int unsigned SPSW_PTR_LO      = 4;
  localparam int unsigned SPSW_DATA_HI     = 3;
  localparam int unsigned SPSW_DIAG_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration pointers
  localparam logic [1:0] SPSW_PTR_NONE     = 2'h0;
  localparam logic [1:0] SPSW_PTR_PWM_LED  = 2'h1;
  localparam logic [1:0] SPSW_PTR_HW       = 2'h2;
  localparam logic [1:0] SPSW_PTR_DIAG     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [5:0] SPSW_CHAN_RST     = 6'h00;
  localparam logic [3:0] SPSW_PWM_LED_RST  = 4'h0;
  localparam logic [3:0] SPSW_HW_RST       = 4'h2;
  localparam logic [3:0] SPSW_DIAG_RST     = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // hardware setup fields
  localparam int unsigned SPSW_HW_CTRL_BIT = 0;
  localparam int unsigned SPSW_HW_STBY_BIT = 1;
  localparam int unsigned SPSW_HW_SRST_BIT = 1;

  // diagnosis setup fields
  localparam int unsigned SPSW_DG_MODE_BIT = 3;
  localparam logic        SPSW_DG_MODE_VAL = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // what the next frame shifts out
  typedef enum logic [1:0] {
    SPSW_RD_DIAG,
    SPSW_RD_OUT,
    SPSW_RD_CFG
  } spsw_read_t;

endpackage : spsw_pkg

// ==== verilog/spsw_sync.sv ====
// spsw_sync: two-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is an independent level; no bus coherence implied.
`timescale 1ns/100ps
module spsw_sync #(
  parameter int unsigned         WIDTH   = 1,
  parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // levels
  input  wire logic [WIDTH-1:0]  async_in,
  output logic      [WIDTH-1:0]  sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : spsw_sync

// ==== verilog/spsw_port.sv ====
// spsw_port: serial command port of a six-channel power switch.
// assumes the serial pins and fault levels are asynchronous to sys_clk and
// that the serial clock is much slower than sys_clk (edges found by sampling).
`timescale 1ns/100ps

// Function
// - good multiple-of-eight frame clears error flag
// - bad count or reset sets error flag
// - error flag on output before first rise
// - bit 6 selects channel or config bank
// - write 10 loads six channel controls
// - write 11 stores data at pointer
// - reads answered in the following frame
// - read reply carries 1, bank, data
// - command in reply frame still executes
// - bit 0 requests standard diagnosis reply
// - fault flag set on channel failure
// - diagnosis bit 6 shows limp-home level
// - registers reset to 00, 00, 02, 07
// - decode only after nonzero multiple of eight
// - bad frame discarded, registers untouched
// - sample falling, shift rising, msb first
module spsw_port
  import spsw_pkg::*;
#(
  parameter int unsigned CHANNELS = SPSW_CHANNELS
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // serial pins
  input  wire logic                spi_cs_n,
  input  wire logic                spi_sclk,
  input  wire logic                spi_si,
  output logic                     spi_so,
  output logic                     spi_so_oe,
  // power stage status
  input  wire logic [CHANNELS-1:0] channel_fault,
  input  wire logic                limp_home_level,
  // register contents to the power stages
  output logic [CHANNELS-1:0]      channel_on,
  output logic [3:0]               pwm_led_setup,
  output logic [3:0]               hardware_setup,
  output logic [3:0]               diagnosis_setup,
  output logic                     frame_error_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  localparam int unsigned SW = CHANNELS + 4;

  logic [SW-1:0]       sync_bus;
  logic                cs_n_s;
  logic                sclk_s;
  logic                si_s;
  logic                limp_s;
  logic [CHANNELS-1:0] fault_s;

  // one bundle keeps every pin at the same two-flop delay
  spsw_sync #(
    .WIDTH   (SW),
    .RST_VAL ({{CHANNELS{1'b0}}, 4'h9})
  ) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in ({channel_fault, limp_home_level, spi_si, spi_sclk, spi_cs_n}),
    .sync_out (sync_bus)
  );

  assign cs_n_s  = sync_bus[0];
  assign sclk_s  = sync_bus[1];
  assign si_s    = sync_bus[2];
  assign limp_s  = sync_bus[3];
  assign fault_s = sync_bus[SW-1:4];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection
  logic cs_n_d_reg;
  logic sclk_d_reg;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cs_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_n_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign cs_fall   = cs_n_d_reg & ~cs_n_s;
  assign cs_rise   = ~cs_n_d_reg & cs_n_s;
  // serial clock ignored while deselected
  assign sclk_rise = ~cs_n_s & ~sclk_d_reg & sclk_s;
  assign sclk_fall = ~cs_n_s & sclk_d_reg & ~sclk_s;

  ////////////////////////////////////////////////////////////////////////////
  // registers and pending read
  logic [CHANNELS-1:0]   chan_reg;
  logic [3:0]            pwm_led_reg;
  logic                  hw_ctrl_bit_reg;
  logic                  standby_state_reg;
  logic [2:0]            diag_mux_reg;
  logic                  fef_reg;
  spsw_read_t            rd_kind_reg;
  logic [1:0]            rd_ptr_reg;
  logic [7:0]            shift_reg;
  logic [SPSW_CNT_W-1:0] bit_cnt_reg;
  logic                  got_byte_reg;
  logic                  so_reg;
  logic                  so_oe_reg;

  // config register contents as read back
  function automatic logic [3:0] cfg_read(input logic [1:0] ptr);
    logic [3:0] v;
    v = 4'h0;
    if (ptr == SPSW_PTR_PWM_LED) begin
      v = pwm_led_reg;
    end else if (ptr == SPSW_PTR_HW) begin
      v = {2'b00, standby_state_reg, hw_ctrl_bit_reg};
    end else if (ptr == SPSW_PTR_DIAG) begin
      v = {SPSW_DG_MODE_VAL, diag_mux_reg};
    end
    return v;
  endfunction : cfg_read

  ////////////////////////////////////////////////////////////////////////////
  // frame end decode
  logic       frame_ok;
  logic       cmd_write;
  logic       cmd_bank;
  logic [1:0] cmd_ptr;
  logic [3:0] cmd_data;
  logic       soft_rst;

  // a frame is good on a nonzero multiple of eight falling edges
  assign frame_ok  = cs_rise & got_byte_reg & (bit_cnt_reg == '0);
  assign cmd_write = shift_reg[SPSW_WRITE_BIT];
  assign cmd_bank  = shift_reg[SPSW_BANK_BIT];
  assign cmd_ptr   = shift_reg[SPSW_PTR_HI:SPSW_PTR_LO];
  assign cmd_data  = shift_reg[SPSW_DATA_HI:0];
  // writing the reset bit of hardware setup restores all register defaults but not the error flag
  assign soft_rst  = frame_ok & cmd_write & cmd_bank & (cmd_ptr == SPSW_PTR_HW)
                     & cmd_data[SPSW_HW_SRST_BIT];

  // good write frame aimed at one register bank; clocked callers only
  function automatic logic write_to_bank(input logic bank);
    return frame_ok & cmd_write & (cmd_bank == bank);
  endfunction : write_to_bank

  // channel controls
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      chan_reg <= SPSW_CHAN_RST;
    end else if (write_to_bank(1'b0)) begin
      chan_reg <= shift_reg[CHANNELS-1:0];
    end
  end

  // configuration bank; pointer 00 writes nothing
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      pwm_led_reg       <= SPSW_PWM_LED_RST;
      hw_ctrl_bit_reg   <= SPSW_HW_RST[SPSW_HW_CTRL_BIT];
      standby_state_reg <= SPSW_HW_RST[SPSW_HW_STBY_BIT];
      diag_mux_reg      <= SPSW_DIAG_RST[2:0];
    end else if (write_to_bank(1'b1)) begin
      if (cmd_ptr == SPSW_PTR_PWM_LED) begin
        pwm_led_reg <= cmd_data;
      end else if (cmd_ptr == SPSW_PTR_HW) begin
        hw_ctrl_bit_reg   <= cmd_data[SPSW_HW_CTRL_BIT];
        // a write without the reset bit leaves standby
        standby_state_reg <= 1'b0;
      end else if (cmd_ptr == SPSW_PTR_DIAG) begin
        diag_mux_reg <= cmd_data[2:0];
      end
    end
  end

  // error flag: set on reset and bad frame, cleared by good frame
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fef_reg <= 1'b1;
    end else if (cs_rise) begin
      fef_reg <= ~frame_ok;
    end
  end

  // pending read chosen by the last frame; writes and bad frames fall back to diagnosis
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_kind_reg <= SPSW_RD_DIAG;
      rd_ptr_reg  <= SPSW_PTR_NONE;
    end else if (cs_rise) begin
      rd_ptr_reg <= cmd_ptr;
      if (!frame_ok || cmd_write || shift_reg[SPSW_DIAG_BIT]) begin
        rd_kind_reg <= SPSW_RD_DIAG;
      end else if (cmd_bank) begin
        rd_kind_reg <= SPSW_RD_CFG;
      end else begin
        rd_kind_reg <= SPSW_RD_OUT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply selection
  logic [7:0] reply;

  always_comb begin
    reply = 8'h00;
    case (rd_kind_reg)
      SPSW_RD_OUT: begin
        reply = {1'b1, 1'b0, chan_reg};
      end
      SPSW_RD_CFG: begin
        reply = {1'b1, 1'b1, rd_ptr_reg, cfg_read(rd_ptr_reg)};
      end
      default: begin
        reply = {1'b0, limp_s, fault_s};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift path; one register serves both directions so bytes pass through
  // in a chain of devices
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
    end else if (cs_fall) begin
      shift_reg <= reply;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[6:0], si_s};
    end
  end

  // falling edge counter; wraps every eight bits
  always_ff @(posedge sys_clk) begin
    if (!nrst || cs_fall) begin
      bit_cnt_reg  <= '0;
      got_byte_reg <= 1'b0;
    end else if (sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == SPSW_CNT_W'(SPSW_FRAME_BITS - 1)) begin
        got_byte_reg <= 1'b1;
      end
    end
  end

  // output enable follows select through the same synchroniser delay
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= ~cs_n_s;
    end
  end

  // output pin: error flag merged with input until first rising edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      so_reg <= 1'b0;
    end else begin
      if (cs_fall) begin
        so_reg <= fef_reg | si_s;
      end else if (sclk_rise) begin
        so_reg <= shift_reg[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      spi_so           <= 1'b0;
      spi_so_oe        <= 1'b0;
      channel_on       <= SPSW_CHAN_RST;
      pwm_led_setup    <= SPSW_PWM_LED_RST;
      hardware_setup   <= SPSW_HW_RST;
      diagnosis_setup  <= SPSW_DIAG_RST;
      frame_error_flag <= 1'b1;
    end else begin
      spi_so           <= so_reg;
      spi_so_oe        <= so_oe_reg;
      channel_on       <= chan_reg;
      pwm_led_setup    <= pwm_led_reg;
      hardware_setup   <= cfg_read(SPSW_PTR_HW);
      diagnosis_setup  <= cfg_read(SPSW_PTR_DIAG);
      frame_error_flag <= fef_reg;
    end
  end

endmodule : spsw_port

// ==== sim/spsw_port_monitor.sv ====
// spsw_port_monitor: port assertions of the serial switch port.
// assumes serial phases of at least 4 sys_clk cycles.
`timescale 1ns/100ps
module spsw_port_monitor
  import spsw_pkg::*;
#(
  parameter int unsigned CHANNELS = SPSW_CHANNELS
) (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                nrst,
  // serial pins
  input wire logic                spi_cs_n,
  input wire logic                spi_sclk,
  input wire logic                spi_si,
  input wire logic                spi_so,
  input wire logic                spi_so_oe,
  // status and registers
  input wire logic [CHANNELS-1:0] channel_fault,
  input wire logic                limp_home_level,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic [3:0]          pwm_led_setup,
  input wire logic [3:0]          hardware_setup,
  input wire logic [3:0]          diagnosis_setup,
  input wire logic                frame_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // select settled for a while: pin delays have drained
  sequence cs_held;
    $stable(spi_cs_n)[*7];
  endsequence
  sequence cs_drop;
    $fell(spi_cs_n);
  endsequence
  a_reset_vals:
    assert property ($rose(nrst) |-> channel_on == '0 && pwm_led_setup == 4'h0 &&
      hardware_setup == 4'h2 && diagnosis_setup == 4'h7 && frame_error_flag)
    else $error("reset values wrong");
  a_oe_on_fall:
    assert property (cs_drop |-> ##[3:6] spi_so_oe)
    else $error("so not driven after select");
  a_oe_off_rise:
    assert property ($rose(spi_cs_n) |-> ##[3:6] !spi_so_oe)
    else $error("so still driven after deselect");
  a_oe_tracks_cs:
    assert property (cs_held |-> spi_so_oe == !spi_cs_n)
    else $error("so enable disagrees with select");
  a_flag_leads:
    assert property ($rose(spi_so_oe) && frame_error_flag |-> spi_so)
    else $error("error flag not shown first");
  a_regs_quiet:
    assert property (cs_held |-> $stable(channel_on) && $stable(pwm_led_setup) &&
      $stable(hardware_setup) && $stable(diagnosis_setup) && $stable(frame_error_flag))
    else $error("register moved without decode");
  a_update_late:
    assert property ($changed(channel_on) || $changed(frame_error_flag) ||
      $changed(hardware_setup) |-> $past(spi_cs_n, 3) && !$past(spi_cs_n, 9))
    else $error("update not tied to select rise");
  a_fixed_bits:
    assert property (hardware_setup[3:2] == 2'h0 && diagnosis_setup[3] == 1'b0)
    else $error("read-only setup bits nonzero");
endmodule : spsw_port_monitor

bind spsw_port spsw_port_monitor #(.CHANNELS(CHANNELS)) u_mon (.sys_clk, .nrst, .spi_cs_n,
  .spi_sclk, .spi_si, .spi_so, .spi_so_oe, .channel_fault, .limp_home_level, .channel_on,
  .pwm_led_setup, .hardware_setup, .diagnosis_setup, .frame_error_flag);

// ==== sim/spsw_host.sv ====
// spsw_host: behavioural serial master, one frame per call.
// assumes sys_clk runs; 32 ns phases stay off the sys_clk grid.
`timescale 1ns/100ps
module spsw_host (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_si,
  input  wire logic spi_so
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si   = 1'b0;
  end
  // beyond 8 clocks the byte repeats, as a chain would
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx, output logic fl);
    int i;
    rx = 8'h00;
    @(negedge sys_clk);
    #1.3;
    spi_cs_n = 1'b0;
    #64;
    fl = spi_so;
    for (i = 0; i < n; i++) begin
      spi_si   = tx[7 - i % 8];
      spi_sclk = 1'b1;
      #32;
      if (i < 8) rx[7 - i] = spi_so;
      spi_sclk = 1'b0;
      #32;
    end
    // si has a pull-down once released
    spi_si   = 1'b0;
    #32;
    spi_cs_n = 1'b1;
    #64;
  endtask : xfer
endmodule : spsw_host

// ==== sim/testbench.sv ====
// testbench: serial frames with expected replies and flags.
// assumes the host model on the pins and the bound checker.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench;
  // {sent byte, expected reply}
  localparam logic [15:0] TBL [17] = '{16'h006A, 16'h5080, 16'h60D0, 16'h70E2, 16'h40F7,
    16'hABC0, 16'hD56A, 16'hE16A, 16'hFD6A, 16'hC96A, 16'h506A, 16'h60D5, 16'h70E1,
    16'h00F5, 16'h01AB, 16'h006A, 16'h00AB};
  logic       sys_clk, nrst, limp_home_level, fl;
  logic [5:0] channel_fault;
  logic [7:0] rx;
  int         num_errors, tests_run, k;
  wire        spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe, so_pin, frame_error_flag;
  wire  [5:0] channel_on;
  wire  [3:0] pwm_led_setup, hardware_setup, diagnosis_setup;
  assign so_pin = spi_so_oe ? spi_so : 1'bz;
  spsw_port uut (.sys_clk, .nrst, .spi_cs_n, .spi_sclk, .spi_si, .spi_so, .spi_so_oe,
    .channel_fault, .limp_home_level, .channel_on, .pwm_led_setup, .hardware_setup,
    .diagnosis_setup, .frame_error_flag);
  spsw_host host (.sys_clk, .spi_cs_n, .spi_sclk, .spi_si, .spi_so(so_pin));
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    channel_fault = 6'h2A;
    limp_home_level = 1'b1;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    // chained reads and writes, reply overlaps next command
    for (k = 0; k < 17; k++) begin
      host.xfer(TBL[k][15:8], 8, rx, fl);
      `CHK(rx, TBL[k][7:0])
      `CHK(fl, k == 0)
    end
    `CHK(channel_on, 6'h2B)
    `CHK(pwm_led_setup, 4'h5)
    `CHK(hardware_setup, 4'h1)
    `CHK(diagnosis_setup, 4'h5)
    // short frame must be dropped
    @(negedge sys_clk);
    channel_fault = 6'h15;
    limp_home_level = 1'b0;
    host.xfer(8'h80, 5, rx, fl);
    `CHK(channel_on, 6'h2B)
    host.xfer(8'h00, 8, rx, fl);
    `CHK(fl, 1'b1)
    `CHK(rx, 8'h15)
    host.xfer(8'h00, 8, rx, fl);
    `CHK(fl, 1'b0)
    `CHK(rx, 8'hAB)
    host.xfer(8'h00, 0, rx, fl);
    `CHK(fl, 1'b0)
    `CHK(frame_error_flag, 1'b1)
    // empty frame, then two bytes: last byte counts
    host.xfer(8'h81, 16, rx, fl);
    `CHK(fl, 1'b1)
    `CHK(rx, 8'h15)
    `CHK(channel_on, 6'h01)
    host.xfer(8'hE2, 8, rx, fl);
    `CHK(frame_error_flag, 1'b0)
    `CHK(channel_on, 6'h00)
    `CHK(pwm_led_setup, 4'h0)
    `CHK(hardware_setup, 4'h2)
    `CHK(diagnosis_setup, 4'h7)
    summarize();
  end
endmodule : testbench
